/* iss_div.sv */
// Purpose: unsigned restoring divider, one quotient bit per cycle
// Assumes: start is ignored while busy; divide by zero gives all ones
// Notes: done is a one-cycle pulse W+1 cycles after start
`timescale 1ns/1ps
module iss_div #(
  parameter int unsigned W = 64
) (
  input logic clk,
  input logic reset_n,
  input logic start,
  input logic [W-1:0] num,
  input logic [W-1:0] den,
  output logic busy,
  output logic done,
  output logic [W-1:0] quo
);
  typedef struct packed {
    logic [W-1:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] den;
    logic [7:0] cnt;
    logic busy;
    logic done;
  } iss_div_s;

  iss_div_s s, n;
  logic [W:0] r;

  always_comb begin
    n = s;
    n.done = 1'b0;
    r = '0;
    if (start && !s.busy) begin
      n.rem = '0;
      n.quo = num;
      n.den = den;
      n.cnt = 8'(W);
      n.busy = 1'b1;
    end else if (s.busy) begin
      r = {s.rem, s.quo[W-1]};
      n.quo = {s.quo[W-2:0], 1'b0};
      if (r >= {1'b0, s.den}) begin
        r = r - {1'b0, s.den};
        n.quo[0] = 1'b1;
      end
      n.rem = r[W-1:0];
      n.cnt = s.cnt - 8'h01;
      if (s.cnt == 8'h01) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign busy = s.busy;
  assign done = s.done;
  assign quo = s.quo;
endmodule

/* iss_partner.sv */
// Purpose: host scan sequencer and the ten converters facing the sinc block
// Assumes: samples packed a few cycles apart instead of 96 us, to keep runs short
// Notes: converters run free, so one stray sample lands in the overhead, two after
`timescale 1ns/1ps
module iss_partner #(
  parameter int OVH = 20
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] n_samp,
  input wire logic quad,
  input wire logic conv_resync,
  output logic scan_start,
  output iss_pkg::iss_samp_s samp
);
  import iss_pkg::*;
  int k;

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      samp.valid <= 1'b0;
      samp.data <= ~samp.data;
    end
  endtask

  task automatic put(input logic junk);
    @(posedge clk);
    samp.valid <= 1'b1;
    for (int c = 0; c < N_CH; c++)
      samp.data[c] <= junk ? 24'h7FFFFF : 24'(c * 1000 - 5000 + (quad ? k * k : 3 * k));
  endtask

  initial begin
    scan_start = 1'b0;
    samp = '0;
    k = 0;
    forever begin
      @(posedge clk);
      samp.valid <= 1'b0;
      samp.data <= ~samp.data;
      if (go) begin
        scan_start <= 1'b1;
        @(posedge clk);
        scan_start <= 1'b0;
        while (conv_resync !== 1'b1) @(posedge clk);
        step(4);
        put(1'b1);
        step(OVH);
        for (k = 0; k < n_samp; k++) begin
          put(1'b0);
          step(3);
        end
        put(1'b1);
        step(1);
        put(1'b1);
      end
    end
  end
endmodule

/* iss_pkg.sv */
// Purpose: shared constants, states and carriers of the sinc filter block
// Assumes: 125 MHz clock, one base sample every 96 us per channel
// Notes: times in microseconds, counts derived from the clock rate
package iss_pkg;
  localparam int CLK_MHZ = 125;
  localparam int SAMPLE_US = 96;
  localparam int OVERHEAD_US = 1320;
  localparam int OVERHEAD_CYC = OVERHEAD_US * CLK_MHZ;
  localparam int MIN_SCAN_US = 1520;
  localparam int MIN_INTEG_US = 192;
  localparam int V2C_US = 1520;
  localparam int REV_US = 420;
  localparam int AVAIL_MIN_US = 200;
  localparam int MAX_FILT_SAMP = 680;
  localparam int MAX_ORD = 5;
  localparam int N_CH = 10;
  localparam int SAMP_W = 24;
  // longest integration per order; order 1 keeps no history
  localparam int MAX_INTEG [0:5] = '{0, 0, 32640, 21792, 16320, 13056};
  // comb weights C(order,k) for k below the order
  localparam int BINOM [0:5][0:4] = '{'{0, 0, 0, 0, 0}, '{1, 0, 0, 0, 0},
    '{1, 2, 0, 0, 0}, '{1, 3, 3, 0, 0}, '{1, 4, 6, 4, 0}, '{1, 5, 10, 10, 5}};

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PERIOD = 8'h04;
  localparam logic [7:0] A_IPARAM = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_AVAIL = 8'h10;
  localparam logic [7:0] A_INTEG = 8'h14;
  localparam logic [7:0] A_GROUP = 8'h18;
  localparam logic [7:0] A_NSAMP = 8'h1C;
  localparam logic [7:0] A_RES = 8'h20;
  localparam logic [7:0] A_NONE = 8'hFF;

  localparam int B_PLAN = 0;
  localparam int B_OSR = 1;
  localparam int B_REV = 2;
  localparam int B_EN = 3;
  localparam int B_CONFLICT = 4;
  localparam int B_NEWRES = 5;

  typedef enum logic [3:0] {
    P_IDLE, P_AVAIL, P_WAIT, P_AUTO_ORD, P_AUTO_FIT, P_FIT,
    P_F_G, P_F_U, P_F_L, P_F_I, P_POW
  } iss_plan_e;

  typedef enum logic [2:0] {R_IDLE, R_OVH, R_SAMP, R_NORM, R_NDIV} iss_run_e;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } iss_ahb_s;

  typedef struct packed {
    logic valid;
    logic [N_CH-1:0][SAMP_W-1:0] data;
  } iss_samp_s;
endpackage

/* iss_sinc_top.sv */
// Purpose: scan planning and sinc-n filtering for ten isolated channels
// Assumes: AHB-Lite register access, converter samples synchronous to clk
// Notes: one result per channel per scan, read from the result registers
// Overview of operation
// [RQ1] resync converters, wait 1320 us overhead each scan
// [RQ2] host period exceeds overhead plus integration time
// [RQ3] samples per scan equal integration over 96
// [RQ4] auto order from available and integration time
// [RQ5] available time from period, sense, reversal
// [RQ6] auto mode rejects available time at most 200
// [RQ7] first order gives plain window average
// [RQ8] order N cascades N equal-length averages
// [RQ9] stored samples are order times (L-1) plus one
// [RQ10] auto mode lowers order above 680 samples
// [RQ11] first order accumulates without sample storage
// [RQ12] integration limits per order two to five
// [RQ13] negative parameter forces order, maximizes integration
// [RQ14] forced order needs (order+1)*96 available
// [RQ15] forced order pre-averages to at most 680
// [RQ16] forced order integration from group and order
// [RQ17] report integration time and order to software
// [RQ18] one setting per module, conflicts rejected
// [RQ19] accumulators wide enough for full window
// [RQ20] one result per channel after window ends
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module iss_sinc_top #(
  parameter int unsigned ACC_W = 64,
  parameter int unsigned OVH_CYC = iss_pkg::OVERHEAD_CYC
) (
  input logic clk,
  input logic reset_n,
  input iss_pkg::iss_ahb_s ahb,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input logic scan_start,
  input iss_pkg::iss_samp_s samp,
  output logic conv_resync,
  output logic result_ready
);
  import iss_pkg::*;

  typedef struct packed {
    logic hrdy;
    logic wpend;
    logic [7:0] waddr;
    logic [31:0] hrd;
    logic [31:0] period;
    logic [31:0] iparam;
    logic osr;
    logic rev;
    logic en;
    iss_plan_e pst;
    iss_plan_e pret;
    logic [2:0] order;
    logic [31:0] avail;
    logic [31:0] integ;
    logic [31:0] grp;
    logic [31:0] len;
    logic [31:0] nsamp;
    logic [31:0] dq;
    logic [ACC_W-1:0] divsr;
    logic [2:0] mcnt;
    logic ok;
    logic err_int;
    logic err_cfg;
    logic conflict;
    logic dstart;
    logic [ACC_W-1:0] dnum;
    logic [ACC_W-1:0] dden;
    iss_run_e rst;
    logic [31:0] ocnt;
    logic [31:0] gcnt;
    logic [31:0] sidx;
    logic [3:0] ch;
    logic neg;
    logic [N_CH-1:0][ACC_W-1:0] gsum;
    logic [N_CH-1:0][MAX_ORD-1:0][ACC_W-1:0] intg;
    logic [N_CH-1:0][MAX_ORD-1:0][ACC_W-1:0] snap;
    logic [N_CH-1:0][31:0] res;
    logic resync;
    logic rdy;
    logic new_res;
  } iss_state_s;

  iss_state_s s, n;
  logic signed [31:0] av_c;
  logic [ACC_W-1:0] num_c;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] xs [N_CH];
  logic [31:0] wd;
  logic [7:0] ra;
  logic d_done;
  logic [ACC_W-1:0] d_quo;

  iss_div #(.W(ACC_W)) u_div (
    .clk(clk),
    .reset_n(reset_n),
    .start(s.dstart),
    .num(s.dnum),
    .den(s.dden),
    .busy(),
    .done(d_done),
    .quo(d_quo)
  );

  function automatic logic [31:0] rd_fn(input iss_state_s t, input logic [7:0] a);
    logic [31:0] r;
    logic [7:0] idx;
    r = 32'h0000_0000;
    idx = (a - A_RES) >> 2;
    if (a == A_CTRL) begin
      r = {28'h0, t.en, t.rev, t.osr, 1'b0};
    end else if (a == A_PERIOD) begin
      r = t.period;
    end else if (a == A_IPARAM) begin
      r = t.iparam;
    end else if (a == A_STATUS) begin
      r = {21'h0, t.order, 2'h0, t.new_res, t.conflict, t.err_cfg, t.err_int, t.ok,
           (t.pst != P_IDLE) || (t.rst != R_IDLE)};
    end else if (a == A_AVAIL) begin
      r = t.avail;
    end else if (a == A_INTEG) begin
      r = t.integ; // RQ17
    end else if (a == A_GROUP) begin
      r = t.grp;
    end else if (a == A_NSAMP) begin
      r = t.nsamp;
    end else if (a >= A_RES && a < A_RES + 8'(4 * N_CH) && a[1:0] == 2'h0) begin
      r = t.res[idx[3:0]];
    end
    return r;
  endfunction

  always_comb begin
    n = s;
    n.hrdy = 1'b1;
    n.wpend = 1'b0;
    n.dstart = 1'b0;
    n.resync = 1'b0;
    n.rdy = 1'b0;
    wd = ahb.hwdata;
    acc = '0;
    ra = A_NONE;
    // available time, evaluated from live configuration
    av_c = signed'(s.period); // RQ5
    if (s.osr) av_c = av_c - V2C_US; // RQ5
    if (s.rev) av_c = (av_c >>> 1) - REV_US; // RQ5
    av_c = av_c - OVERHEAD_US; // RQ5
    // comb stages folded into one weighted sum of integrator snapshots
    num_c = '0;
    for (int k = 0; k < MAX_ORD; k++) begin
      if (k < int'(s.order)) begin
        if (k[0]) num_c = num_c - ACC_W'(BINOM[s.order][k]) * s.snap[s.ch][k]; // RQ8
        else num_c = num_c + ACC_W'(BINOM[s.order][k]) * s.snap[s.ch][k]; // RQ8
      end
    end
    for (int c = 0; c < N_CH; c++) begin
      xs[c] = s.gsum[c] + {{(ACC_W - SAMP_W){samp.data[c][SAMP_W-1]}}, samp.data[c]};
    end

    // data phase of a write
    if (s.wpend) begin
      if (s.waddr == A_CTRL) begin
        if (s.en && (wd[B_OSR] != s.osr || wd[B_REV] != s.rev)) begin
          n.conflict = 1'b1; // RQ18
        end else if (wd[B_OSR] != s.osr || wd[B_REV] != s.rev) begin
          n.osr = wd[B_OSR];
          n.rev = wd[B_REV];
          n.ok = 1'b0;
        end
        n.en = wd[B_EN];
        if (wd[B_PLAN]) begin
          if (!wd[B_EN] && !s.en && s.pst == P_IDLE && s.rst == R_IDLE) begin
            n.pst = P_AVAIL;
            n.ok = 1'b0;
            n.err_int = 1'b0;
            n.err_cfg = 1'b0;
          end else begin
            n.conflict = 1'b1;
          end
        end
      end else if (s.waddr == A_PERIOD) begin
        if (s.en && wd != s.period) n.conflict = 1'b1; // RQ18
        else if (!s.en) begin
          n.period = wd;
          n.ok = 1'b0;
        end
      end else if (s.waddr == A_IPARAM) begin
        if (s.en && wd != s.iparam) n.conflict = 1'b1; // RQ18
        else if (!s.en) begin
          n.iparam = wd;
          n.ok = 1'b0;
        end
      end else if (s.waddr == A_STATUS) begin
        if (wd[B_CONFLICT]) n.conflict = 1'b0;
        if (wd[B_NEWRES]) n.new_res = 1'b0;
      end
    end

    // planning: every division goes through the shared divider
    case (s.pst)
      P_AVAIL: begin
        n.grp = 32'h1;
        n.divsr = ACC_W'(1);
        n.mcnt = 3'h0;
        n.avail = av_c;
        if (!s.iparam[31] && s.iparam != 32'h0) begin
          n.integ = s.iparam;
          if (av_c <= AVAIL_MIN_US) begin
            n.err_int = 1'b1; // RQ6
            n.pst = P_IDLE;
          end else if (s.iparam < 32'(MIN_INTEG_US)) begin
            n.err_cfg = 1'b1;
            n.pst = P_IDLE;
          end else begin
            n.dstart = 1'b1; // RQ3
            n.dnum = ACC_W'(s.iparam);
            n.dden = ACC_W'(SAMPLE_US);
            n.pret = P_AUTO_ORD;
            n.pst = P_WAIT;
          end
        end else if (signed'(s.iparam) >= -MAX_ORD && s.iparam != 32'h0) begin
          n.order = 3'(-s.iparam); // RQ13
          if (av_c < (32'(-signed'(s.iparam)) + 1) * SAMPLE_US) begin
            n.err_int = 1'b1; // RQ14
            n.pst = P_IDLE;
          end else begin
            n.dstart = 1'b1;
            n.dnum = ACC_W'(unsigned'(av_c));
            n.dden = ACC_W'(SAMPLE_US);
            n.pret = P_F_G;
            n.pst = P_WAIT;
          end
        end else begin
          n.err_cfg = 1'b1;
          n.pst = P_IDLE;
        end
      end
      P_WAIT: begin
        if (d_done) begin
          n.dq = d_quo[31:0];
          n.pst = s.pret;
        end
      end
      P_AUTO_ORD: begin
        n.len = s.dq; // RQ3
        n.dstart = 1'b1; // RQ4
        n.dnum = ACC_W'(s.avail - 32'(SAMPLE_US));
        n.dden = ACC_W'(s.integ - 32'(SAMPLE_US));
        n.pret = P_AUTO_FIT;
        n.pst = P_WAIT;
      end
      P_AUTO_FIT: begin
        if (s.dq == 32'h0) begin
          n.err_int = 1'b1;
          n.pst = P_IDLE;
        end else begin
          n.order = (s.dq > 32'(MAX_ORD)) ? 3'(MAX_ORD) : s.dq[2:0]; // RQ4
          n.pst = P_FIT;
        end
      end
      P_FIT: begin
        // same as order*(L-1)+1 above 680 when integration is a whole multiple of 96; one step down per cycle
        if (s.order >= 3'h2 && s.integ > 32'(MAX_INTEG[s.order])) begin
          n.order = s.order - 3'h1; // RQ10 RQ12
        end else begin
          n.pst = P_POW;
        end
      end
      P_F_G: begin
        n.dstart = 1'b1; // RQ15
        n.dnum = ACC_W'(s.dq - 32'h1);
        n.dden = ACC_W'(MAX_FILT_SAMP);
        n.pret = P_F_U;
        n.pst = P_WAIT;
      end
      P_F_U: begin
        n.grp = s.dq + 32'h1; // RQ15
        n.dstart = 1'b1;
        n.dnum = ACC_W'(s.avail);
        n.dden = ACC_W'(32'(SAMPLE_US) * (s.dq + 32'h1));
        n.pret = P_F_L;
        n.pst = P_WAIT;
      end
      P_F_L: begin
        n.dstart = 1'b1; // RQ16
        n.dnum = ACC_W'(s.dq - 32'h1);
        n.dden = ACC_W'(s.order);
        n.pret = P_F_I;
        n.pst = P_WAIT;
      end
      P_F_I: begin
        n.len = s.dq + 32'h1; // RQ16
        n.integ = (s.dq + 32'h1) * 32'(SAMPLE_US) * s.grp; // RQ16
        n.pst = P_POW;
      end
      P_POW: begin
        // normalizer (group * length) ^ order
        if (s.mcnt < s.order) begin
          n.divsr = s.divsr * (ACC_W'(s.grp) * ACC_W'(s.len)); // RQ7
          n.mcnt = s.mcnt + 3'h1;
        end else begin
          n.nsamp = 32'(s.order) * (s.len - 32'h1) + 32'h1; // RQ9
          n.ok = 1'b1;
          n.pst = P_IDLE;
        end
      end
      default: ;
    endcase

    // scan: a start during normalization is dropped, divider still busy
    if (scan_start && s.en && s.ok && s.pst == P_IDLE
        && s.rst != R_NORM && s.rst != R_NDIV) begin
      n.resync = 1'b1; // RQ1
      n.rst = R_OVH;
      n.ocnt = 32'h0;
      n.gcnt = 32'h0;
      n.sidx = 32'h0;
      n.gsum = '0;
      n.intg = '0;
      n.snap = '0;
    end else begin
      case (s.rst)
        R_OVH: begin
          if (s.ocnt >= 32'(OVH_CYC - 1)) n.rst = R_SAMP; // RQ1
          else n.ocnt = s.ocnt + 32'h1;
        end
        R_SAMP: begin
          if (samp.valid) begin
            if (s.gcnt == s.grp - 32'h1) begin
              n.gcnt = 32'h0;
              for (int c = 0; c < N_CH; c++) begin
                n.gsum[c] = '0;
                acc = xs[c];
                // integrators only; no per-sample history kept
                for (int j = 0; j < MAX_ORD; j++) begin
                  acc = s.intg[c][j] + acc; // RQ11 RQ19
                  n.intg[c][j] = acc;
                end
                for (int k = 0; k < MAX_ORD; k++) begin
                  if (k < int'(s.order)
                      && s.sidx + 32'(k) * s.len == s.nsamp - 32'h1) begin
                    n.snap[c][k] = n.intg[c][s.order - 3'h1]; // RQ8
                  end
                end
              end
              n.sidx = s.sidx + 32'h1;
              if (s.sidx == s.nsamp - 32'h1) begin
                n.rst = R_NORM; // RQ20
                n.ch = 4'h0;
              end
            end else begin
              for (int c = 0; c < N_CH; c++) n.gsum[c] = xs[c]; // RQ15
              n.gcnt = s.gcnt + 32'h1;
            end
          end
        end
        R_NORM: begin
          n.neg = num_c[ACC_W-1];
          n.dstart = 1'b1; // RQ7
          n.dnum = num_c[ACC_W-1] ? -num_c : num_c;
          n.dden = s.divsr;
          n.rst = R_NDIV;
        end
        R_NDIV: begin
          if (d_done) begin
            n.res[s.ch] = s.neg ? 32'(-d_quo) : d_quo[31:0]; // RQ20
            if (s.ch == 4'(N_CH - 1)) begin
              n.rdy = 1'b1;
              n.new_res = 1'b1;
              n.rst = R_IDLE;
            end else begin
              n.ch = s.ch + 4'h1;
              n.rst = R_NORM;
            end
          end
        end
        default: ;
      endcase
    end

    // address phase; read data sees this cycle's updates
    if (ahb.hsel && ahb.htrans[1] && ahb.hready) begin
      if (ahb.haddr[31:8] == 24'h0) ra = ahb.haddr[7:0];
      if (ahb.hwrite) begin
        n.wpend = 1'b1;
        n.waddr = ra;
      end else begin
        n.hrd = rd_fn(n, ra); // RQ17
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.hrdy;
  assign hrdata = s.hrd;
  assign hresp = 1'b0;
  assign conv_resync = s.resync;
  assign result_ready = s.rdy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_resync_on_start: assert property ( // RQ1
    (scan_start && s.en && s.ok && s.pst == P_IDLE && s.rst == R_IDLE)
      |=> conv_resync ##1 (s.rst == R_OVH))
    else $error("scan start did not resync converters");
  chk_overhead_len: assert property ( // RQ1
    (s.rst == R_SAMP && $past(s.rst) == R_OVH) |-> $past(s.ocnt) == 32'(OVH_CYC - 1))
    else $error("overhead wait ended at the wrong count");
  chk_auto_too_short: assert property ( // RQ6
    (s.pst == P_AVAIL && !s.iparam[31] && s.iparam != 0 && av_c <= AVAIL_MIN_US)
      |=> s.err_int && s.pst == P_IDLE)
    else $error("short available time not rejected");
  chk_forced_short: assert property ( // RQ14
    (s.pst == P_AVAIL && s.iparam[31] && signed'(s.iparam) >= -MAX_ORD
      && av_c < (32'(-signed'(s.iparam)) + 1) * SAMPLE_US) |=> s.err_int)
    else $error("forced order accepted too little time");
  chk_order_range: assert property ( // RQ4
    s.ok |-> (s.order >= 3'h1 && s.order <= 3'(MAX_ORD)))
    else $error("filter order out of range");
  chk_sample_limit: assert property ( // RQ10
    (s.ok && s.order >= 3'h2) |-> s.nsamp <= 32'(MAX_FILT_SAMP))
    else $error("filter fed with too many samples");
  chk_forced_order: assert property ( // RQ13
    (s.ok && s.iparam[31]) |-> 32'(s.order) == -s.iparam)
    else $error("forced order not applied");
  chk_max_integ: assert property ( // RQ12
    (s.ok && !s.iparam[31] && s.order >= 3'h2) |-> s.integ <= 32'(MAX_INTEG[s.order]))
    else $error("integration above limit for order");
  chk_integ_units: assert property ( // RQ16
    s.ok |-> s.integ == s.len * 32'(SAMPLE_US) * s.grp)
    else $error("integration not a whole number of groups");
  chk_window_done: assert property ( // RQ20
    (s.rst == R_NORM && $past(s.rst) == R_SAMP) |-> s.sidx == s.nsamp)
    else $error("window ended at the wrong sample");
  chk_ready_after: assert property ( // RQ20
    result_ready |-> $past(s.rst) == R_NDIV && s.new_res)
    else $error("result ready without normalization");

  cov_auto_plan: cover property (s.pst == P_POW ##1 s.ok && !s.iparam[31]);
  cov_forced_plan: cover property (s.pst == P_F_I ##1 s.pst == P_POW);
  cov_result: cover property (result_ready);
  cov_conflict: cover property ($rose(s.conflict));
endmodule

/* iss_sinc_top_test.sv */
// Purpose: register-level regression of scan planning and sinc filtering
// Assumes: overhead shortened to 20 cycles; converters modelled by the partner
// Notes: every expected figure is reworked here from the planning arithmetic
`timescale 1ns/1ps
module iss_sinc_top_test;
  import iss_pkg::*;
  localparam int OVH = 20;
  logic clk, reset_n, hsel, hwrite, go, quad;
  logic hreadyout, hresp, scan_start, conv_resync, result_ready;
  logic [1:0] htrans;
  logic [15:0] n_samp;
  logic [31:0] haddr, hwdata, hrdata, rd, msk;
  iss_ahb_s ahb;
  iss_samp_s samp;
  int mismatches, n_checks, cycles, av, o, g, ex;
  int per_t[6] = '{2376, 1520, 1521, 200000, 200000, 1720};
  int ip_t[6] = '{288, 192, 192, 21792, 21888, 100};
  int per_f[8] = '{2376, 2376, 2376, 2376, 2376, 2000000, 1895, 1896};
  int ord_f[8] = '{1, 2, 3, 4, 5, 5, 5, 5};

  // word transfers only, and hready is the lone slave's own
  assign ahb = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, hreadyout};

  iss_sinc_top #(.ACC_W(64), .OVH_CYC(OVH)) u_iss_sinc_top (.clk(clk), .reset_n(reset_n),
    .ahb(ahb), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .scan_start(scan_start), .samp(samp), .conv_resync(conv_resync),
    .result_ready(result_ready));
  iss_partner #(.OVH(OVH)) u_iss_partner (.clk(clk), .go(go), .n_samp(n_samp),
    .quad(quad), .conv_resync(conv_resync), .scan_start(scan_start), .samp(samp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic plan(input int per, input int ip, input logic [31:0] fl);
    xfer(1'b1, A_PERIOD, per);
    xfer(1'b1, A_IPARAM, ip);
    xfer(1'b1, A_CTRL, fl | 32'h1);
    rd = 32'h1;
    for (int i = 0; i < 300 && rd[0] !== 1'b0; i++) xfer(1'b0, A_STATUS, 32'h0);
  endtask

  function automatic int avail_of(input int per, input logic osr, input logic rev);
    int a;
    a = per - (osr ? V2C_US : 0);
    if (rev) a = a / 2 - REV_US;
    return a - OVERHEAD_US;
  endfunction

  function automatic int auto_ord(input int a, input int ip);
    int r;
    r = (a - SAMPLE_US) / (ip - SAMPLE_US);
    if (r > MAX_ORD) r = MAX_ORD;
    while (r > 1 && r * (ip / SAMPLE_US - 1) + 1 > MAX_FILT_SAMP) r--;
    return r;
  endfunction

  // quad ramp checks truncation of the plain mean; linear ramp checks the centre
  task automatic scan(input int per, input int n, input logic q);
    plan(per, 288, 32'h0);
    xfer(1'b1, A_CTRL, 32'h8);
    n_samp <= 16'(n);
    quad <= q;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    check(conv_resync, 1'b1);
    for (int i = 0; i < 3000 && result_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check({31'h0, result_ready}, 32'h1);
    for (int c = 0; c < N_CH; c++) begin
      ex = q ? (3 * (c * 1000 - 5000) + 5) / 3 : c * 1000 - 5000 + 15;
      rdchk(A_RES + 8'(4 * c), ex);
    end
    xfer(1'b0, A_STATUS, 32'h0);
    check(rd & 32'h20, 32'h20);
    xfer(1'b1, A_CTRL, 32'h0);
  endtask

  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    go = 1'b0;
    quad = 1'b0;
    n_samp = 16'h0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(A_STATUS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      plan(per_t[i], ip_t[i], 32'h0);
      av = avail_of(per_t[i], 1'b0, 1'b0);
      o = auto_ord(av, ip_t[i]);
      ex = ip_t[i] < MIN_INTEG_US ? 8 : av <= AVAIL_MIN_US ? 4 : 2 + (o << 8);
      msk = ex > 8 ? 32'h70F : 32'hF;
      xfer(1'b0, A_STATUS, 32'h0);
      check(rd & msk, ex);
      if (ex > 8) begin
        rdchk(A_AVAIL, av);
        rdchk(A_INTEG, ip_t[i]);
        rdchk(A_NSAMP, o == 1 ? ip_t[i] / 96 : o * (ip_t[i] / 96 - 1) + 1);
      end
    end
    for (int i = 0; i < 8; i++) begin
      o = ord_f[i];
      plan(per_f[i], -o, i == 5 ? 32'h6 : 32'h0);
      av = avail_of(per_f[i], i == 5, i == 5);
      g = (av / SAMPLE_US - 1) / MAX_FILT_SAMP + 1;
      ex = av < (o + 1) * SAMPLE_US ? 4 : 2 + (o << 8);
      xfer(1'b0, A_STATUS, 32'h0);
      check(rd & (ex > 8 ? 32'h70F : 32'hF), ex);
      if (ex > 8) begin
        rdchk(A_AVAIL, av);
        rdchk(A_GROUP, g);
        rdchk(A_INTEG, ((av / (96 * g) - 1) / o + 1) * 96 * g);
      end
    end
    xfer(1'b1, A_CTRL, 32'h8);
    xfer(1'b1, A_PERIOD, 32'h5);
    rdchk(A_PERIOD, 32'd1896);
    xfer(1'b0, A_STATUS, 32'h0);
    check(rd & 32'h10, 32'h10);
    xfer(1'b1, A_STATUS, 32'h10);
    xfer(1'b0, A_STATUS, 32'h0);
    check(rd & 32'h10, 32'h0);
    rdchk(8'h80, 32'h0);
    xfer(1'b1, A_CTRL, 32'h0);
    scan(1720, 3, 1'b1);
    scan(2376, 11, 1'b0);
    end_sim();
  end
endmodule
